// ---- logic/pwr_mon_pkg.sv ----
// Package for the power-good, reset and thermal monitor.
// Assumes a single free-running 20 MHz system clock.
package pwr_mon_pkg;

  // Timebase
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;

  // Reset extension after main power becomes good, in ms
  localparam int unsigned RESET_EXT_MS    = 24;
  localparam int unsigned RESET_EXT_CYC   = CLK_PER_MS * RESET_EXT_MS;

  // Thermal alarm qualification time, in s
  localparam int unsigned THERMAL_ALARM_N_QUAL_S    = 2;
  localparam int unsigned THERMAL_ALARM_N_QUAL_CYC  = CLK_HZ * THERMAL_ALARM_N_QUAL_S;

  // Timer counter width, wide enough for the longest count
  localparam int unsigned CNT_W           = 26;

  // Thermal alarm tracking, one-hot
  typedef enum logic [2:0] {
    THERMAL_ALARM_N_IDLE     = 3'h1,
    THERMAL_ALARM_N_ALARM    = 3'h2,
    THERMAL_ALARM_N_OVERRIDE = 3'h4
  } thermal_alarm_n_state_t;

  typedef struct packed {
    thermal_alarm_n_state_t thermal_alarm_n;
    logic         alarm_prev;
    logic         alert_prev;
    logic         cpu_rst;
    logic         pci_rst_n;
    logic         resume_rst;
    logic         rtc_rst;
    logic         rtc_stable;
    logic         sci;
    logic         smi_n;
    logic         gpe;
    logic         override_evt;
    logic         throttle;
    logic         wake;
  } mon_state_t;

  // Everything held in reset, no events pending
  localparam mon_state_t MON_RESET = '{
    thermal_alarm_n:        THERMAL_ALARM_N_IDLE,
    alarm_prev:   1'b0,
    alert_prev:   1'b0,
    cpu_rst:      1'b1,
    pci_rst_n:    1'b0,
    resume_rst:   1'b1,
    rtc_rst:      1'b1,
    rtc_stable:   1'b0,
    sci:          1'b0,
    smi_n:        1'b1,
    gpe:          1'b0,
    override_evt: 1'b0,
    throttle:     1'b0,
    wake:         1'b0
  };

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             done;
  } tmr_state_t;

  localparam tmr_state_t TMR_RESET = '{cnt: '0, done: 1'b0};

endpackage

// ---- logic/qual_timer_if.sv ----
// Carrier between the monitor and its qualification timers.
// Both ends share the monitor's clock.
`timescale 1ns/10ps
interface qual_timer_if;
  logic run;
  logic done;

  modport timer (
    input  run,
    output done
  );

  modport user (
    output run,
    input  done
  );
endinterface

// ---- logic/qual_timer.sv ----
// Level qualification timer: done rises once run has stayed high LIMIT cycles.
// Assumes run is synchronous to clk_sys_i; dropping run restarts the count.
`timescale 1ns/10ps
module qual_timer #(
  parameter logic [pwr_mon_pkg::CNT_W-1:0] LIMIT = 26'h000_0001
) (
  // Clock and reset
  input  wire logic           clk_sys_i,
  input  wire logic           reset_i,
  input  wire logic           ce_i,
  // Run request and qualified answer
  qual_timer_if.timer         tmr
);

  pwr_mon_pkg::tmr_state_t q;
  pwr_mon_pkg::tmr_state_t d;

  always_comb begin
    d = q;
    if (!tmr.run) begin
      d = pwr_mon_pkg::TMR_RESET;
    end else if (q.cnt == LIMIT - 1'b1) begin
      d.done = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q <= pwr_mon_pkg::TMR_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign tmr.done = q.done;

endmodule // qual_timer

// ---- logic/power_good_reset_thermal_monitor.sv ----
// Power-good to reset sequencing, thermal alarm handling and SMBus alert routing.
// Assumes all pins synchronous to clk_sys_i, which keeps running while main
// power is unstable.
`timescale 1ns/10ps

module power_good_reset_thermal_monitor #(
  parameter int unsigned RESET_EXT_CYCLES  = pwr_mon_pkg::RESET_EXT_CYC,
  parameter int unsigned THERMAL_ALARM_N_QUAL_CYCLES = pwr_mon_pkg::THERMAL_ALARM_N_QUAL_CYC
) (
  // Clock, reset, clock enable
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // Power-good inputs and RTC enable
  input  wire logic main_power_good_i,
  input  wire logic standby_power_good_i,
  input  wire logic battery_power_good_i,
  input  wire logic rtc_enable_i,
  // Event sources
  input  wire logic thermal_alarm_n_i,
  input  wire logic smbus_alert_in_n_i,
  input  wire logic sleeping_i,
  // Event routing enables
  input  wire logic thermal_alarm_n_sci_en_i,
  input  wire logic thermal_alarm_n_smi_en_i,
  input  wire logic thermal_alarm_n_gpe_en_i,
  input  wire logic alert_wake_en_i,
  input  wire logic alert_sci_en_i,
  input  wire logic alert_smi_en_i,
  input  wire logic alert_gpe_en_i,
  // Processor, PCI and well resets, RTC power stable
  output logic      processor_reset_o,
  output logic      pci_bus_reset_out_n_o,
  output logic      resume_well_reset_o,
  output logic      rtc_well_reset_o,
  output logic      rtc_power_stable_o,
  // Events and thermal control
  output logic      sci_o,
  output logic      system_mgmt_interrupt_n_o,
  output logic      general_event_irq_o,
  output logic      wake_o,
  output logic      thermal_override_o,
  output logic      throttle_o
);

  localparam logic [pwr_mon_pkg::CNT_W-1:0] RST_LIMIT =
    pwr_mon_pkg::CNT_W'(RESET_EXT_CYCLES);
  localparam logic [pwr_mon_pkg::CNT_W-1:0] THERMAL_ALARM_N_LIMIT =
    pwr_mon_pkg::CNT_W'(THERMAL_ALARM_N_QUAL_CYCLES);

  pwr_mon_pkg::mon_state_t q;
  pwr_mon_pkg::mon_state_t d;

  qual_timer_if rst_tmr ();
  qual_timer_if thermal_alarm_n_tmr ();

  logic alarm_act;
  logic alert_act;
  logic alarm_rise;
  logic alert_rise;
  logic alert_wake;
  logic alert_irq;

  assign alarm_act  = ~thermal_alarm_n_i;
  assign alert_act  = ~smbus_alert_in_n_i;
  assign alarm_rise = alarm_act & ~q.alarm_prev;
  assign alert_rise = alert_act & ~q.alert_prev;
  // Asleep with alert_wake_en_i set, the alert wakes the system; otherwise it is an interrupt source
  assign alert_wake = alert_rise & sleeping_i & alert_wake_en_i;
  assign alert_irq  = alert_rise & ~alert_wake;

  // Timers count system clocks, which run regardless of main power
  assign rst_tmr.run   = main_power_good_i;
  assign thermal_alarm_n_tmr.run = alarm_act;

  qual_timer #(
    .LIMIT (RST_LIMIT)
  ) u_rst_timer (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .tmr       (rst_tmr.timer)
  );

  qual_timer #(
    .LIMIT (THERMAL_ALARM_N_LIMIT)
  ) u_thermal_alarm_n_timer (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .tmr       (thermal_alarm_n_tmr.timer)
  );

  always_comb begin
    d = q;
    d.alarm_prev = alarm_act;
    d.alert_prev = alert_act;

    // Processor and PCI resets follow the qualified main power good
    d.cpu_rst   = ~(main_power_good_i & rst_tmr.done);
    d.pci_rst_n = main_power_good_i & rst_tmr.done;

    // Resume well reset straight from standby power good
    d.resume_rst = ~standby_power_good_i;

    // RTC well held in reset unless the internal clock is enabled and battery power is good
    d.rtc_stable = rtc_enable_i & battery_power_good_i;
    d.rtc_rst    = ~(rtc_enable_i & battery_power_good_i);

    // Event pulses last one cycle
    d.sci          = (alarm_rise & thermal_alarm_n_sci_en_i) | (alert_irq & alert_sci_en_i);
    d.smi_n        = ~((alarm_rise & thermal_alarm_n_smi_en_i) | (alert_irq & alert_smi_en_i));
    d.gpe          = (alarm_rise & thermal_alarm_n_gpe_en_i) | (alert_irq & alert_gpe_en_i);
    d.wake         = alert_wake;
    d.override_evt = 1'b0;

    case (q.thermal_alarm_n)
      pwr_mon_pkg::THERMAL_ALARM_N_IDLE: begin
        d.throttle = 1'b0;
        if (alarm_act) begin
          d.thermal_alarm_n = pwr_mon_pkg::THERMAL_ALARM_N_ALARM;
        end
      end
      pwr_mon_pkg::THERMAL_ALARM_N_ALARM: begin
        if (!alarm_act) begin
          d.thermal_alarm_n = pwr_mon_pkg::THERMAL_ALARM_N_IDLE;
        end else if (thermal_alarm_n_tmr.done) begin
          d.thermal_alarm_n        = pwr_mon_pkg::THERMAL_ALARM_N_OVERRIDE;
          d.override_evt = 1'b1;
          d.throttle     = 1'b1;
        end
      end
      pwr_mon_pkg::THERMAL_ALARM_N_OVERRIDE: begin
        // Throttling holds until the alarm goes away
        if (!alarm_act) begin
          d.thermal_alarm_n    = pwr_mon_pkg::THERMAL_ALARM_N_IDLE;
          d.throttle = 1'b0;
        end
      end
      default: begin
        d.thermal_alarm_n    = pwr_mon_pkg::THERMAL_ALARM_N_IDLE;
        d.throttle = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q <= pwr_mon_pkg::MON_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign processor_reset_o         = q.cpu_rst;
  assign pci_bus_reset_out_n_o     = q.pci_rst_n;
  assign resume_well_reset_o       = q.resume_rst;
  assign rtc_well_reset_o          = q.rtc_rst;
  assign rtc_power_stable_o        = q.rtc_stable;
  assign sci_o                     = q.sci;
  assign system_mgmt_interrupt_n_o = q.smi_n;
  assign general_event_irq_o       = q.gpe;
  assign wake_o                    = q.wake;
  assign thermal_override_o        = q.override_evt;
  assign throttle_o                = q.throttle;

endmodule // power_good_reset_thermal_monitor

// ---- verification/pwr_board_model.sv ----
// Board side: supplies, thermal sensor and SMBus alert source.
// Assumes bench requests change just after the rising edge.
`timescale 1ns/10ps
module pwr_board_model (
  // Clock and requests
  input  wire logic clk_sys_i,
  input  wire logic main_req_i,
  input  wire logic rtc_used_i,
  input  wire logic hot_i,
  input  wire logic alert_i,
  // Pins
  output logic      main_pg_o,
  output logic      standby_pg_o,
  output logic      battery_pg_o,
  output logic      alarm_n_o,
  output logic      alert_n_o
);
  initial {main_pg_o, standby_pg_o, battery_pg_o, alarm_n_o, alert_n_o} = 5'h03;
  always @(posedge clk_sys_i) begin
    main_pg_o    <= main_req_i;
    standby_pg_o <= main_req_i;
    battery_pg_o <= rtc_used_i;
    alarm_n_o    <= ~hot_i;
    alert_n_o    <= ~alert_i;
  end
endmodule // pwr_board_model

// ---- verification/power_good_reset_thermal_monitor_props.sv ----
// Port checker of the monitor, bound into each instance.
// Assumes ce_i held high; counters track power-good and alarm age.
`timescale 1ns/10ps
module pwr_mon_props #(
  parameter int unsigned RESET_EXT_CYCLES  = 8,
  parameter int unsigned THERMAL_ALARM_N_QUAL_CYCLES = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic main_power_good_i,
  input wire logic standby_power_good_i,
  input wire logic battery_power_good_i,
  input wire logic rtc_enable_i,
  input wire logic thermal_alarm_n_i,
  input wire logic smbus_alert_in_n_i,
  input wire logic sleeping_i,
  input wire logic thermal_alarm_n_sci_en_i,
  input wire logic thermal_alarm_n_smi_en_i,
  input wire logic alert_wake_en_i,
  input wire logic alert_gpe_en_i,
  input wire logic processor_reset_o,
  input wire logic pci_bus_reset_out_n_o,
  input wire logic resume_well_reset_o,
  input wire logic rtc_well_reset_o,
  input wire logic rtc_power_stable_o,
  input wire logic sci_o,
  input wire logic system_mgmt_interrupt_n_o,
  input wire logic general_event_irq_o,
  input wire logic wake_o,
  input wire logic thermal_override_o,
  input wire logic throttle_o
);
  int unsigned pg_age_q;
  int unsigned hot_age_q;
  always_ff @(posedge clk_sys_i) begin
    pg_age_q  <= (reset_i || !main_power_good_i) ? '0 : pg_age_q + 1;
    hot_age_q <= (reset_i || thermal_alarm_n_i) ? '0 : hot_age_q + 1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence alarm_qualified;
    hot_age_q == THERMAL_ALARM_N_QUAL_CYCLES + 1;
  endsequence
  sequence wake_onset;
    $fell(smbus_alert_in_n_i) && sleeping_i && alert_wake_en_i;
  endsequence
  resume_follow_a: assert property (
    !$past(reset_i) |-> resume_well_reset_o == !$past(standby_power_good_i))
    else $error("resume well reset wrong");
  rtc_follow_a: assert property (
    !$past(reset_i) |-> rtc_well_reset_o != rtc_power_stable_o &&
    rtc_power_stable_o == $past(rtc_enable_i && battery_power_good_i))
    else $error("rtc well state wrong");
  pg_low_a: assert property (
    !$past(reset_i) && !$past(main_power_good_i) |-> processor_reset_o && !pci_bus_reset_out_n_o)
    else $error("resets not asserted");
  reset_hold_a: assert property (
    pg_age_q <= RESET_EXT_CYCLES |-> processor_reset_o && !pci_bus_reset_out_n_o)
    else $error("resets released early");
  reset_release_a: assert property (
    pg_age_q > RESET_EXT_CYCLES |-> !processor_reset_o && pci_bus_reset_out_n_o)
    else $error("resets released late");
  thermal_alarm_n_sci_a: assert property (
    $fell(thermal_alarm_n_i) && thermal_alarm_n_sci_en_i |=> sci_o) else $error("no thermal sci");
  thermal_alarm_n_smi_a: assert property (
    $fell(thermal_alarm_n_i) && thermal_alarm_n_smi_en_i |=> !system_mgmt_interrupt_n_o)
    else $error("no thermal smi");
  alert_wake_a: assert property (
    wake_onset |=> wake_o) else $error("no wake");
  alert_gpe_a: assert property (
    $fell(smbus_alert_in_n_i) && !(sleeping_i && alert_wake_en_i) && alert_gpe_en_i
    |=> general_event_irq_o) else $error("no alert gpe");
  override_a: assert property (
    alarm_qualified |-> ##[0:2] (thermal_override_o && throttle_o))
    else $error("no thermal override");
  early_throttle_a: assert property (
    $rose(throttle_o) |-> hot_age_q > THERMAL_ALARM_N_QUAL_CYCLES) else $error("throttle early");
endmodule // pwr_mon_props
bind power_good_reset_thermal_monitor pwr_mon_props #(
  .RESET_EXT_CYCLES(RESET_EXT_CYCLES),
  .THERMAL_ALARM_N_QUAL_CYCLES(THERMAL_ALARM_N_QUAL_CYCLES)
) i_pwr_mon_props (.*);

// ---- verification/power_good_reset_thermal_monitor_test.sv ----
// Self-checking bench of the power-good, reset and thermal monitor.
// Assumes the board model on the pins and the bound checker.
`timescale 1ns/10ps
`define chk(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module power_good_reset_thermal_monitor_test;
  logic clk_sys_i, reset_i, ce_i, main_power_good_i, standby_power_good_i, rtc_enable_i;
  logic battery_power_good_i, thermal_alarm_n_i, smbus_alert_in_n_i, sleeping_i;
  logic thermal_alarm_n_sci_en_i, thermal_alarm_n_smi_en_i, thermal_alarm_n_gpe_en_i, alert_wake_en_i, alert_sci_en_i;
  logic alert_smi_en_i, alert_gpe_en_i, processor_reset_o, pci_bus_reset_out_n_o;
  logic resume_well_reset_o, rtc_well_reset_o, rtc_power_stable_o, sci_o, wake_o;
  logic system_mgmt_interrupt_n_o, general_event_irq_o, thermal_override_o, throttle_o;
  logic main_req, hot, alert;
  logic [4:0] exp_q[$];
  logic [31:0] lfsr;
  int errors, cmp_count;
  wire [4:0] ev = {sci_o, ~system_mgmt_interrupt_n_o, general_event_irq_o, wake_o,
                   thermal_override_o};
  power_good_reset_thermal_monitor #(.RESET_EXT_CYCLES(8), .THERMAL_ALARM_N_QUAL_CYCLES(16))
    i_power_good_reset_thermal_monitor (.*);
  pwr_board_model i_pwr_board_model (.clk_sys_i, .main_req_i(main_req),
    .rtc_used_i(rtc_enable_i), .hot_i(hot), .alert_i(alert),
    .main_pg_o(main_power_good_i), .standby_pg_o(standby_power_good_i),
    .battery_pg_o(battery_power_good_i), .alarm_n_o(thermal_alarm_n_i),
    .alert_n_o(smbus_alert_in_n_i));
  function automatic logic [31:0] next_rand(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic complete_run;
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Each event pulse is matched against the oldest note
  always @(negedge clk_sys_i) begin
    logic [4:0] note;
    if (ev !== 5'h00) begin
      if (exp_q.size() == 0) `chk(ev, 5'h00)
      else begin
        // Take the note once, so a mismatch print cannot pop a second one
        note = exp_q.pop_front();
        `chk(ev, note)
      end
    end
  end
  initial begin
    {reset_i, ce_i, main_req, hot, alert, rtc_enable_i, sleeping_i} = 7'h60;
    {thermal_alarm_n_sci_en_i, thermal_alarm_n_smi_en_i, thermal_alarm_n_gpe_en_i, alert_wake_en_i} = 4'h0;
    {alert_sci_en_i, alert_smi_en_i, alert_gpe_en_i} = 3'h0;
    errors = 0;
    cmp_count = 0;
    lfsr = 32'h5038_f6c9;
    tick(8);
    reset_i <= 1'b0;
    main_req <= 1'b1;
    tick(5);
    main_req <= 1'b0;
    tick(3);
    @(negedge clk_sys_i);
    `chk({processor_reset_o, pci_bus_reset_out_n_o}, 2'b10)
    `chk({resume_well_reset_o, rtc_power_stable_o, rtc_well_reset_o}, 3'b101)
    tick(1);
    main_req <= 1'b1;
    rtc_enable_i <= 1'b1;
    tick(12);
    @(negedge clk_sys_i);
    `chk({processor_reset_o, pci_bus_reset_out_n_o}, 2'b01)
    `chk({resume_well_reset_o, rtc_power_stable_o, rtc_well_reset_o}, 3'b010)
    for (int i = 0; i < 8; i++) begin
      tick(1);
      {thermal_alarm_n_gpe_en_i, thermal_alarm_n_smi_en_i, thermal_alarm_n_sci_en_i} <= 3'(i);
      if (i != 0) exp_q.push_back({i[0], i[1], i[2], 2'b00});
      hot <= 1'b1;
      tick(3);
      hot <= 1'b0;
      tick(2);
    end
    tick(1);
    exp_q.push_back(5'h1c);
    exp_q.push_back(5'h01);
    hot <= 1'b1;
    tick(22);
    @(negedge clk_sys_i);
    `chk(throttle_o, 1'b1)
    tick(1);
    hot <= 1'b0;
    tick(3);
    @(negedge clk_sys_i);
    `chk(throttle_o, 1'b0)
    for (int i = 0; i < 8; i++) begin
      logic [4:0] r;
      lfsr = next_rand(lfsr);
      r = lfsr[4:0] | ((i == 0) ? 5'h18 : 5'h00);
      tick(1);
      {sleeping_i, alert_wake_en_i, alert_sci_en_i, alert_smi_en_i, alert_gpe_en_i} <= r;
      if (r[4] && r[3]) exp_q.push_back(5'h02);
      else if (r[2:0] != 3'h0) exp_q.push_back({r[2:0], 2'b00});
      alert <= 1'b1;
      tick(3);
      alert <= 1'b0;
      tick(2);
    end
    tick(4);
    `chk(exp_q.size(), 0)
    complete_run();
  end
endmodule // power_good_reset_thermal_monitor_test
